// File: shared/obs_pkg.sv
// Constants and types shared by the operand barrel shifter files
package obs_pkg;

    localparam int          DATA_W       = 32;
    localparam int          AMT_W        = 8;
    localparam int          IMM_W        = 8;
    localparam int          POS_W        = 5;

    // Shift amount and immediate landmarks
    localparam logic [7:0]  AMT_NONE     = 8'h00;
    localparam logic [7:0]  AMT_FULL     = 8'h20;
    localparam logic [7:0]  AMT_OVER     = 8'h21;
    localparam logic [4:0]  IMM_POS_MAX  = 5'h18;
    localparam logic [31:0] IMM_SMALL    = 32'h0000_00ff;

    // Values after reset
    localparam logic [31:0] RST_OPERAND  = 32'h0000_0000;
    localparam logic        RST_CARRY    = 1'h0;
    localparam logic        RST_UPDATE   = 1'h0;
    localparam logic        RST_VALID    = 1'h0;

    // Result is ready one clock after the request
    localparam int          LATENCY      = 1;

    typedef enum logic [2:0] {
        SH_LEFT,
        SH_RIGHT,
        SH_ARITH,
        SH_ROTATE,
        SH_EXTEND
    } obs_shift_e;

    typedef enum logic [1:0] {
        IMM_SHIFTED,
        IMM_REP_EVEN,
        IMM_REP_ODD,
        IMM_REP_ALL
    } obs_imm_e;

endpackage

// File: shared/obs_shift_if.sv
// Signals between the top level and the shift core
interface obs_shift_if;
    import obs_pkg::*;

    logic [DATA_W-1:0] src;
    obs_shift_e        kind;
    logic [AMT_W-1:0]  amt;
    logic              cin;
    logic [DATA_W-1:0] result;
    logic              cout;
    logic              active;

    modport core (
        input  src,
        input  kind,
        input  amt,
        input  cin,
        output result,
        output cout,
        output active
    );

    modport user (
        output src,
        output kind,
        output amt,
        output cin,
        input  result,
        input  cout,
        input  active
    );
endinterface

// File: rtl/obs_shift_core.sv
// Combinational barrel shifter for the register form of the second operand
module obs_shift_core
    import obs_pkg::*;
(
    // Shift request and answer
    obs_shift_if.core p
);

    logic [DATA_W:0]     wide;
    logic [2*DATA_W-1:0] dbl;

    always_comb begin
        wide     = '0;
        dbl      = '0;
        p.result = p.src;
        p.cout   = p.cin;
        p.active = 1'b0;
        case (p.kind)
            SH_LEFT: begin
                // Amount zero is the plain pass-through
                if (p.amt != AMT_NONE) begin
                    wide     = {1'b0, p.src} << p.amt;
                    p.result = wide[DATA_W-1:0];
                    p.cout   = wide[DATA_W];
                    p.active = 1'b1;
                end
            end
            SH_RIGHT: begin
                // Extra low bit catches the last bit shifted out
                if (p.amt != AMT_NONE) begin
                    wide     = {p.src, 1'b0} >> p.amt;
                    p.result = wide[DATA_W:1];
                    p.cout   = wide[0];
                    p.active = 1'b1;
                end
            end
            SH_ARITH: begin
                if (p.amt != AMT_NONE) begin
                    // Kept signed on its own so the fill copies the sign bit
                    wide     = $signed({p.src, 1'b0}) >>> p.amt;
                    p.result = wide[DATA_W:1];
                    p.cout   = wide[0];
                    p.active = 1'b1;
                end
            end
            SH_ROTATE: begin
                // Only the low five bits pick the result; multiples of 32 return the source
                if (p.amt != AMT_NONE) begin
                    dbl      = {p.src, p.src} >> p.amt[4:0];
                    p.result = dbl[DATA_W-1:0];
                    p.cout   = dbl[DATA_W-1];
                    p.active = 1'b1;
                end
            end
            SH_EXTEND: begin
                p.result = {p.cin, p.src[DATA_W-1:1]};
                p.cout   = p.src[0];
                p.active = 1'b1;
            end
            default: begin
                p.result = p.src;
                p.cout   = p.cin;
                p.active = 1'b0;
            end
        endcase
    end

endmodule

// File: rtl/obs_top.sv
// Flexible second operand generator: immediate expander and register shifter
module obs_top
    import obs_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              srst,
    // Request from decode and execute
    input  wire logic              req_valid,
    input  wire logic              use_imm,
    input  wire logic              flag_set,
    input  wire logic              carry_in,
    // Register form
    input  wire logic [DATA_W-1:0] shift_source_register,
    input  wire obs_shift_e        shift_kind,
    input  wire logic [AMT_W-1:0]  shift_amt,
    // Immediate form
    input  wire logic [IMM_W-1:0]  imm_value,
    input  wire obs_imm_e          imm_form,
    input  wire logic [POS_W-1:0]  imm_pos,
    // Answer to the arithmetic unit
    output logic                   res_valid,
    output logic [DATA_W-1:0]      flexible_second_operand,
    output logic                   carry_out,
    output logic                   carry_update
);

    // Positions above 24 push high bits out of the word
    function automatic logic [DATA_W-1:0] obs_expand(
        input obs_imm_e          form,
        input logic [IMM_W-1:0]  val,
        input logic [POS_W-1:0]  pos
    );
        logic [DATA_W-1:0] v;
        v = {{(DATA_W-IMM_W){1'b0}}, val};
        case (form)
            IMM_SHIFTED:  obs_expand = v << pos;
            IMM_REP_EVEN: obs_expand = {8'h00, val, 8'h00, val};
            IMM_REP_ODD:  obs_expand = {val, 8'h00, val, 8'h00};
            IMM_REP_ALL:  obs_expand = {val, val, val, val};
            default:      obs_expand = v;
        endcase
    endfunction

    obs_shift_if sh ();

    logic [DATA_W-1:0] imm_word;
    logic [DATA_W-1:0] next_operand;
    logic              next_carry;
    logic              next_update;
    logic              next_valid;

    // Source is only read, never written back
    assign sh.src  = shift_source_register;
    assign sh.kind = shift_kind;
    assign sh.amt  = shift_amt;
    assign sh.cin  = carry_in;

    obs_shift_core u_core (
        .p (sh.core)
    );

    always_comb begin
        imm_word     = obs_expand(imm_form, imm_value, imm_pos);
        next_valid   = req_valid;
        next_operand = flexible_second_operand;
        next_carry   = carry_in;
        next_update  = 1'b0;
        if (req_valid) begin
            if (use_imm) begin
                next_operand = imm_word;
                // Replicated patterns never touch carry
                if (flag_set && imm_form == IMM_SHIFTED && imm_word > IMM_SMALL) begin
                    next_carry  = imm_word[DATA_W-1];
                    next_update = 1'b1;
                end
            end else begin
                next_operand = sh.result;
                if (flag_set && sh.active) begin
                    next_carry  = sh.cout;
                    next_update = 1'b1;
                end
            end
        end
    end

    // Operand holds its last value between requests to save toggling
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            res_valid               <= RST_VALID;
            flexible_second_operand <= RST_OPERAND;
            carry_out               <= RST_CARRY;
            carry_update            <= RST_UPDATE;
        end else begin
            res_valid               <= next_valid;
            flexible_second_operand <= next_operand;
            carry_out               <= next_carry;
            carry_update            <= next_update;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    property p_valid_follows;
        req_valid |=> res_valid;
    endproperty
    a_valid_follows: assert property (p_valid_follows) else $error("answer not one cycle after request");

    property p_imm_shifted;
        req_valid && use_imm && imm_form == IMM_SHIFTED && imm_pos <= IMM_POS_MAX
        |=> flexible_second_operand == ({24'h0, $past(imm_value)} << $past(imm_pos));
    endproperty
    a_imm_shifted: assert property (p_imm_shifted) else $error("shifted immediate wrong");

    property p_imm_rep;
        req_valid && use_imm && imm_form == IMM_REP_ALL
        |=> flexible_second_operand == {4{$past(imm_value)}} && carry_update == 1'b0;
    endproperty
    a_imm_rep: assert property (p_imm_rep) else $error("replicated immediate wrong");

    property p_imm_carry;
        req_valid && use_imm && flag_set && imm_form == IMM_SHIFTED && imm_value != 8'h00
        && imm_pos != 5'h00 && imm_pos <= IMM_POS_MAX && imm_value[7 -: 1] == 1'b1
        |=> carry_update && carry_out == flexible_second_operand[DATA_W-1];
    endproperty
    a_imm_carry: assert property (p_imm_carry) else $error("immediate carry not from bit 31");

    property p_no_shift;
        req_valid && !use_imm && shift_kind == SH_LEFT && shift_amt == AMT_NONE
        |=> flexible_second_operand == $past(shift_source_register) && !carry_update
            && carry_out == $past(carry_in);
    endproperty
    a_no_shift: assert property (p_no_shift) else $error("zero shift altered value or carry");

    property p_arith;
        req_valid && !use_imm && shift_kind == SH_ARITH && shift_amt != AMT_NONE && shift_amt < AMT_FULL
        |=> flexible_second_operand == DATA_W'($signed($past(shift_source_register)) >>> $past(shift_amt));
    endproperty
    a_arith: assert property (p_arith) else $error("arithmetic shift wrong");

    property p_arith_big;
        req_valid && !use_imm && shift_kind == SH_ARITH && shift_amt >= AMT_FULL
        |=> flexible_second_operand == {DATA_W{$past(shift_source_register[DATA_W-1])}}
            && (!carry_update || carry_out == $past(shift_source_register[DATA_W-1]));
    endproperty
    a_arith_big: assert property (p_arith_big) else $error("large arithmetic shift wrong");

    property p_logical_big;
        req_valid && !use_imm && (shift_kind == SH_LEFT || shift_kind == SH_RIGHT) && shift_amt >= AMT_OVER
        |=> flexible_second_operand == '0 && (!carry_update || !carry_out);
    endproperty
    a_logical_big: assert property (p_logical_big) else $error("logical shift over 32 wrong");

    property p_rot_full;
        req_valid && !use_imm && flag_set && shift_kind == SH_ROTATE && shift_amt == AMT_FULL
        |=> flexible_second_operand == $past(shift_source_register) && carry_update
            && carry_out == $past(shift_source_register[DATA_W-1]);
    endproperty
    a_rot_full: assert property (p_rot_full) else $error("rotate by 32 wrong");

    property p_extend;
        req_valid && !use_imm && flag_set && shift_kind == SH_EXTEND
        |=> flexible_second_operand == {$past(carry_in), $past(shift_source_register[DATA_W-1:1])}
            && carry_update && carry_out == $past(shift_source_register[0]);
    endproperty
    a_extend: assert property (p_extend) else $error("carry rotate wrong");

    property p_carry_pass;
        req_valid && !flag_set |=> !carry_update && carry_out == $past(carry_in);
    endproperty
    a_carry_pass: assert property (p_carry_pass) else $error("carry not passed through");

    property p_left;
        req_valid && !use_imm && flag_set && shift_kind == SH_LEFT && shift_amt != AMT_NONE && shift_amt < AMT_FULL
        |=> flexible_second_operand == ($past(shift_source_register) << $past(shift_amt))
            && carry_update && carry_out == $past(shift_source_register[DATA_W - shift_amt]);
    endproperty
    a_left: assert property (p_left) else $error("left shift wrong");

    property p_right;
        req_valid && !use_imm && flag_set && shift_kind == SH_RIGHT && shift_amt != AMT_NONE && shift_amt < AMT_FULL
        |=> flexible_second_operand == ($past(shift_source_register) >> $past(shift_amt))
            && carry_update && carry_out == $past(shift_source_register[shift_amt - 1]);
    endproperty
    a_right: assert property (p_right) else $error("right shift wrong");

    property p_right_full;
        req_valid && !use_imm && flag_set && shift_kind == SH_RIGHT && shift_amt == AMT_FULL
        |=> flexible_second_operand == '0 && carry_update && carry_out == $past(shift_source_register[DATA_W-1]);
    endproperty
    a_right_full: assert property (p_right_full) else $error("right shift by 32 wrong");

    property p_rotate;
        req_valid && !use_imm && flag_set && shift_kind == SH_ROTATE && shift_amt != AMT_NONE && shift_amt < AMT_FULL
        |=> flexible_second_operand == (($past(shift_source_register) >> $past(shift_amt))
            | ($past(shift_source_register) << (DATA_W - $past(shift_amt))))
            && carry_update && carry_out == $past(shift_source_register[shift_amt - 1]);
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotate wrong");

    property p_imm_even;
        req_valid && use_imm && imm_form == IMM_REP_EVEN
        |=> flexible_second_operand == {8'h00, $past(imm_value), 8'h00, $past(imm_value)} && !carry_update;
    endproperty
    a_imm_even: assert property (p_imm_even) else $error("even byte pattern wrong");

    property p_imm_odd;
        req_valid && use_imm && imm_form == IMM_REP_ODD
        |=> flexible_second_operand == {$past(imm_value), 8'h00, $past(imm_value), 8'h00} && !carry_update;
    endproperty
    a_imm_odd: assert property (p_imm_odd) else $error("odd byte pattern wrong");

    c_imm_carry: cover property (req_valid && use_imm && flag_set |=> carry_update);
    c_arith_big: cover property (req_valid && !use_imm && shift_kind == SH_ARITH && shift_amt >= AMT_FULL);
    c_rotate:    cover property (req_valid && !use_imm && shift_kind == SH_ROTATE && flag_set |=> carry_update);
    c_back2back: cover property (req_valid [*3]);

endmodule

// File: verification/obs_dec_model.sv
// Request source standing in for the decode and execute stage
module obs_dec_model
    import obs_pkg::*;
(
    // Clock
    input  wire logic              sys_clk,
    // Request to the operand generator
    output logic                   req_valid,
    output logic                   use_imm,
    output logic                   flag_set,
    output logic                   carry_in,
    output logic [DATA_W-1:0]      src,
    output obs_shift_e             kind,
    output logic [AMT_W-1:0]       amt,
    output logic [IMM_W-1:0]       imm_value,
    output obs_imm_e               imm_form,
    output logic [POS_W-1:0]       imm_pos
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {req_valid, use_imm, flag_set, carry_in, src, amt, imm_value, imm_pos} = '0;
        kind     = SH_LEFT;
        imm_form = IMM_SHIFTED;
    end

    task automatic issue(input logic ui, fs, ci, input logic [31:0] s, input obs_shift_e k,
                         input logic [7:0] n, v, input obs_imm_e f, input logic [4:0] p, input logic hold);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        use_imm   <= ui;
        flag_set  <= fs;
        carry_in  <= ci;
        src       <= s;
        kind      <= k;
        amt       <= n;
        imm_value <= v;
        imm_form  <= f;
        imm_pos   <= p;
        @(posedge sys_clk);
        // A held request is taken again at the next edge, back to back
        if (!hold) begin
            req_valid <= 1'b0;
            // Released lines must not keep showing the old value
            src       <= ~s;
            imm_value <= ~v;
            carry_in  <= ~ci;
        end
    endtask
endmodule

// File: verification/tb.sv
// Self-checking testbench for the flexible second operand generator
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import obs_pkg::*;

    logic              sys_clk = 1'b0;
    logic              srst    = 1'b1;
    logic              req_valid, use_imm, flag_set, carry_in, res_valid, carry_out, carry_update;
    logic [DATA_W-1:0] src, operand;
    obs_shift_e        kind;
    logic [AMT_W-1:0]  amt;
    logic [IMM_W-1:0]  imm_value;
    obs_imm_e          imm_form;
    logic [POS_W-1:0]  imm_pos;
    int                failures    = 0;
    int                check_count = 0;
    logic [7:0]        corner [6]  = '{8'h00, 8'h01, 8'h1f, 8'h20, 8'h21, 8'hff};

    always #20 sys_clk = ~sys_clk;

    obs_dec_model u_obs_dec_model (.sys_clk(sys_clk), .req_valid(req_valid), .use_imm(use_imm),
        .flag_set(flag_set), .carry_in(carry_in), .src(src), .kind(kind), .amt(amt),
        .imm_value(imm_value), .imm_form(imm_form), .imm_pos(imm_pos));

    obs_top u_obs_top (.sys_clk(sys_clk), .srst(srst), .req_valid(req_valid), .use_imm(use_imm),
        .flag_set(flag_set), .carry_in(carry_in), .shift_source_register(src), .shift_kind(kind),
        .shift_amt(amt), .imm_value(imm_value), .imm_form(imm_form), .imm_pos(imm_pos),
        .res_valid(res_valid), .flexible_second_operand(operand), .carry_out(carry_out),
        .carry_update(carry_update));

    // Wide window: bit 32 or 31 is the last bit out, so huge amounts fall out naturally
    function automatic logic [33:0] exp_shift(logic [31:0] s, obs_shift_e k, logic [7:0] n, logic ci, fs);
        logic [63:0] w;
        logic [31:0] r;
        logic        c;
        logic        u;
        w = {s, 32'h0} >> n;
        r = w[63:32];
        c = w[31];
        if (k == SH_ARITH) begin
            w = $signed({s, 32'h0}) >>> n;
            r = w[63:32];
            c = w[31];
        end else if (k == SH_LEFT) begin
            w = {32'h0, s} << n;
            r = w[31:0];
            c = w[32];
        end else if (k == SH_ROTATE) begin
            w = {s, s} >> n[4:0];
            r = w[31:0];
            c = r[31];
        end else if (k == SH_EXTEND) begin
            r = {ci, s[31:1]};
            c = s[0];
        end
        if (n == 8'h00 && k != SH_EXTEND) begin
            r = s;
        end
        u = fs && (n != 8'h00 || k == SH_EXTEND);
        return {u, u ? c : ci, r};
    endfunction

    function automatic logic [33:0] exp_imm(logic [7:0] v, obs_imm_e f, logic [4:0] p, logic ci, fs);
        logic [31:0] r;
        logic        u;
        case (f)
            IMM_REP_EVEN: r = {2{8'h00, v}};
            IMM_REP_ODD:  r = {2{v, 8'h00}};
            IMM_REP_ALL:  r = {4{v}};
            default:      r = {24'h0, v} << p;
        endcase
        u = fs && f == IMM_SHIFTED && r > IMM_SMALL;
        return {u, u ? r[31] : ci, r};
    endfunction

    task automatic check(logic [34:0] got, logic [34:0] exp, string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic run(logic ui, fs, ci, logic [31:0] s, obs_shift_e k, logic [7:0] n, v,
                       obs_imm_e f, logic [4:0] p, logic hold);
        logic [33:0] e;
        e = ui ? exp_imm(v, f, p, ci, fs) : exp_shift(s, k, n, ci, fs);
        u_obs_dec_model.issue(ui, fs, ci, s, k, n, v, f, p, hold);
        #1;
        check({res_valid, carry_update, carry_out, operand}, {1'b1, e}, "result");
        @(posedge sys_clk);
        #1;
        if (hold) begin
            // Held request is answered again in the very next cycle
            check({res_valid, carry_update, carry_out, operand}, {1'b1, e}, "repeat");
        end else begin
            check({res_valid, carry_update, carry_out, operand}, {2'b00, ~ci, e[31:0]}, "idle");
        end
    endtask

    task automatic wrap_up();
        if (failures == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        wrap_up();
    end

    initial begin
        void'($urandom(27));
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        #1;
        check({res_valid, carry_update, carry_out, operand}, 35'h0, "reset");
        run(1'b0, 1'b1, 1'b0, 32'h0000_000f, SH_RIGHT, 8'h03, 8'h00, IMM_SHIFTED, 5'h00, 1'b0);
        for (int k = 0; k < 5; k++) begin
            for (int i = 0; i < 6; i++) begin
                // Every kind at 0, 1, 31, 32, 33 and 255
                run(1'b0, 1'b1, 1'($urandom), $urandom, obs_shift_e'(k), corner[i], 8'h00, IMM_SHIFTED,
                    5'h00, 1'b0);
            end
        end
        for (int f = 0; f < 4; f++) begin
            for (int i = 0; i < 6; i++) begin
                run(1'b1, 1'b1, 1'($urandom), $urandom, SH_LEFT, 8'h00, 8'h81, obs_imm_e'(f),
                    corner[i][4:0], 1'b0);
            end
        end
        repeat (300) begin
            run(1'($urandom), 1'($urandom), 1'($urandom), $urandom, obs_shift_e'($urandom_range(4, 0)),
                8'($urandom), 8'($urandom), obs_imm_e'($urandom_range(3, 0)), 5'($urandom), 1'($urandom));
        end
        wrap_up();
    end
endmodule
